/* rtl/ccir_defines.vh */
// Constants for the controller clock, interrupt and reset block
`ifndef CCIR_DEFINES_VH
`define CCIR_DEFINES_VH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCIR_CLK_MHZ 125
`define CCIR_QUAL_FAST_NS 1110
`define CCIR_QUAL_SLOW_NS 13300
`define CCIR_QW 11
`define CCIR_POR_CYCLES 16
`define CCIR_TICK_DIV 125
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CCIR_A_CTRL 8'h00
`define CCIR_A_STAT 8'h04
`define CCIR_A_ISTAT 8'h08
`define CCIR_A_IMASK 8'h0c
`define CCIR_A_TCMP 8'h10
`define CCIR_A_TCNT 8'h14
`define CCIR_A_TEST 8'h18
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CCIR_C_SRC 0
`define CCIR_C_F75 1
`define CCIR_C_POL 2
`define CCIR_C_FALL 3
`define CCIR_C_TEXT 4
`define CCIR_C_WAIT 5
`define CCIR_CTRL_W 5
`define CCIR_CTRL_RST 5'h00
`define CCIR_TCMP_RST 8'hff
`define CCIR_TEST_RST 4'h0
// ----------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------
`define CCIR_I_EXT 0
`define CCIR_I_TMR 1
`define CCIR_I_POR 2
`define CCIR_I_WAKE 3
`define CCIR_IW 4
`define CCIR_IMASK_RST 4'h0
// ----------------------------------------------------------------
// Vectors and clock selections
// ----------------------------------------------------------------
`define CCIR_VEC_RST 13'h0000
`define CCIR_VEC_EXT 13'h0001
`define CCIR_VEC_TMR 13'h0003
`define CCIR_SEL_DISC 2'h0
`define CCIR_SEL_FAST 2'h1
`define CCIR_SEL_SLOW 2'h2
`endif

/* rtl/ccir_pulse_qual.v */
// Width qualifier: output follows input only after it stays stable
`timescale 1ns/1ps
module ccir_pulse_qual #(
    parameter W = 11
) (
    input wire clk,
    input wire rst,
    input wire din,
    input wire [W-1:0] thresh,
    output reg dout
);
    reg [W-1:0] cnt_q;

    // Short pulses restart the count and never reach the output
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= {W{1'b0}};
            dout <= 1'b0;
        end else if (din == dout) begin
            cnt_q <= {W{1'b0}};
        end else if (cnt_q >= thresh - 1'b1) begin
            cnt_q <= {W{1'b0}};
            dout <= din;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

/* rtl/ccir_top.v */
// Controller clock select, external interrupt, timer and reset block
//
// Overview of operation
// - Qualified interrupt pulse vectors to address 1
// - Polarity and edge selectable independently
// - Interrupt input clocks timer; match vectors 3
// - Interrupt pin readable as input bit
// - Disc oscillator clocks CPU after reset
// - One bit selects 4.5 MHz or 75 kHz
// - Feedback resistor follows frequency select
// - Oscillator drives system clock and timebase
// - Clock-stop instruction halts controller oscillator
// - Supply rise resets, execution from address 0
// - All four test bits halt disc processor
// - Any hold input change leaves wait
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ccir_defines.vh"
module ccir_top #(
    parameter POR_CYCLES = `CCIR_POR_CYCLES,
    parameter TICK_DIV = `CCIR_TICK_DIV
) (
    input wire CLK,
    input wire SRST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire EXT_IRQ_IN,
    input wire HOLD_IN,
    input wire CTRL_SUPPLY_OK,
    input wire CLOCK_STOP_INSTR,
    output reg CPU_RST,
    output reg [12:0] VEC_ADDR,
    output reg IRQ,
    output reg [1:0] CPU_CLK_SEL,
    output reg [1:0] TIMEBASE_SEL,
    output reg CTRL_XTAL_FB_SEL,
    output reg OSC_RUN,
    output reg CPU_RUN,
    output reg DISC_HALT,
    output reg [3:0] TEST_PORT_BITS
);
    // ------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------
    localparam QUAL_FAST =
        (`CCIR_QUAL_FAST_NS * `CCIR_CLK_MHZ + 999) / 1000;
    localparam QUAL_SLOW =
        (`CCIR_QUAL_SLOW_NS * `CCIR_CLK_MHZ + 999) / 1000;
    localparam [1:0] ST_RUN = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_STOP = 2'b10;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg ext_s1_q, ext_s2_q;
    reg hold_s1_q, hold_s2_q, hold_s3_q;
    reg sup_s1_q, sup_s2_q, sup_s3_q;
    wire hold_chg;
    wire sup_rise;

    always @(posedge CLK) begin
        if (SRST) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            hold_s1_q <= 1'b0;
            hold_s2_q <= 1'b0;
            hold_s3_q <= 1'b0;
            sup_s1_q <= 1'b1;
            sup_s2_q <= 1'b1;
            sup_s3_q <= 1'b1;
        end else begin
            ext_s1_q <= EXT_IRQ_IN;
            ext_s2_q <= ext_s1_q;
            hold_s1_q <= HOLD_IN;
            hold_s2_q <= hold_s1_q;
            hold_s3_q <= hold_s2_q;
            sup_s1_q <= CTRL_SUPPLY_OK;
            sup_s2_q <= sup_s1_q;
            sup_s3_q <= sup_s2_q;
        end
    end

    assign hold_chg = hold_s2_q ^ hold_s3_q;
    assign sup_rise = sup_s2_q & ~sup_s3_q;

    // ------------------------------------------------------------
    // System reset stretcher
    // ------------------------------------------------------------
    // Both the reset pin and a supply rise hold the CPU in reset for
    // the same stretch, so software sees one kind of restart.
    reg por_act_q;
    reg [15:0] por_cnt_q;
    reg por_done;
    wire sys_rst;

    always @(posedge CLK) begin
        if (SRST) begin
            por_act_q <= 1'b1;
            por_cnt_q <= 16'h0000;
            por_done <= 1'b0;
        end else if (sup_rise) begin
            por_act_q <= 1'b1;
            por_cnt_q <= 16'h0000;
            por_done <= 1'b0;
        end else if (por_act_q) begin
            por_done <= 1'b0;
            if (por_cnt_q == POR_CYCLES[15:0] - 16'h0001) begin
                por_act_q <= 1'b0;
                por_done <= 1'b1;
            end else begin
                por_cnt_q <= por_cnt_q + 16'h0001;
            end
        end else begin
            por_done <= 1'b0;
        end
    end

    assign sys_rst = SRST | por_act_q;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    reg [`CCIR_CTRL_W-1:0] ctrl_q;
    reg [`CCIR_IW-1:0] istat_q;
    reg [`CCIR_IW-1:0] imask_q;
    reg [7:0] tcmp_q;
    reg [7:0] tcnt_q;
    reg [1:0] pstate_q;
    reg [1:0] pstate_d;
    wire filt;
    reg hit;
    reg [31:0] rdata;
    wire acc;
    wire wr;
    wire wr_ctrl;
    wire wait_req;

    always @* begin
        case (PADDR)
            `CCIR_A_CTRL, `CCIR_A_STAT, `CCIR_A_ISTAT, `CCIR_A_IMASK,
            `CCIR_A_TCMP, `CCIR_A_TCNT, `CCIR_A_TEST: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    assign acc = PSEL & PENABLE;
    assign wr = acc & PWRITE & ~sys_rst;
    assign PREADY = 1'b1;
    assign PSLVERR = acc & ~hit;
    assign wr_ctrl = wr & (PADDR == `CCIR_A_CTRL);
    assign wait_req = wr_ctrl & PWDATA[`CCIR_C_WAIT];

    always @* begin
        rdata = 32'h00000000;
        case (PADDR)
            `CCIR_A_CTRL: rdata[`CCIR_CTRL_W-1:0] = ctrl_q;
            `CCIR_A_STAT: rdata[5:0] = {DISC_HALT,
                                        pstate_q == ST_WAIT,
                                        pstate_q == ST_STOP,
                                        CTRL_XTAL_FB_SEL,
                                        filt,
                                        ext_s2_q};
            `CCIR_A_ISTAT: rdata[`CCIR_IW-1:0] = istat_q;
            `CCIR_A_IMASK: rdata[`CCIR_IW-1:0] = imask_q;
            `CCIR_A_TCMP: rdata[7:0] = tcmp_q;
            `CCIR_A_TCNT: rdata[7:0] = tcnt_q;
            `CCIR_A_TEST: rdata[3:0] = TEST_PORT_BITS;
            default: rdata = 32'h00000000;
        endcase
    end

    // Read data is captured in the setup cycle so it stands from a
    // flip-flop through the zero-wait access cycle.
    always @(posedge CLK) begin
        if (SRST) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL & ~PENABLE & ~PWRITE) begin
            PRDATA <= rdata;
        end
    end

    always @(posedge CLK) begin
        if (sys_rst) begin
            ctrl_q <= `CCIR_CTRL_RST;
            imask_q <= `CCIR_IMASK_RST;
            tcmp_q <= `CCIR_TCMP_RST;
            TEST_PORT_BITS <= `CCIR_TEST_RST;
        end else if (wr) begin
            case (PADDR)
                `CCIR_A_CTRL: begin
                    ctrl_q <= PWDATA[`CCIR_CTRL_W-1:0];
                end
                `CCIR_A_IMASK: imask_q <= PWDATA[`CCIR_IW-1:0];
                `CCIR_A_TCMP: tcmp_q <= PWDATA[7:0];
                `CCIR_A_TEST: TEST_PORT_BITS <= PWDATA[3:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Oscillator and clock selection
    // ------------------------------------------------------------
    wire src_ctrl = ctrl_q[`CCIR_C_SRC];
    wire f75 = ctrl_q[`CCIR_C_F75];
    wire [1:0] clk_sel = ~src_ctrl ? `CCIR_SEL_DISC :
                         (f75 ? `CCIR_SEL_SLOW : `CCIR_SEL_FAST);

    always @(posedge CLK) begin
        if (sys_rst) begin
            CPU_CLK_SEL <= `CCIR_SEL_DISC;
            TIMEBASE_SEL <= `CCIR_SEL_DISC;
            CTRL_XTAL_FB_SEL <= 1'b0;
            DISC_HALT <= 1'b0;
        end else begin
            CPU_CLK_SEL <= clk_sel;
            TIMEBASE_SEL <= clk_sel;
            CTRL_XTAL_FB_SEL <= f75;
            DISC_HALT <= &TEST_PORT_BITS;
        end
    end

    // ------------------------------------------------------------
    // Power state: run, wait, clock stop
    // ------------------------------------------------------------
    always @* begin
        pstate_d = pstate_q;
        case (pstate_q)
            ST_RUN: begin
                if (CLOCK_STOP_INSTR) begin
                    pstate_d = ST_STOP;
                end else if (wait_req) begin
                    pstate_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (hold_chg) begin
                    pstate_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (hold_chg) begin
                    pstate_d = ST_RUN;
                end
            end
            default: pstate_d = ST_RUN;
        endcase
    end

    always @(posedge CLK) begin
        if (sys_rst) begin
            pstate_q <= ST_RUN;
            OSC_RUN <= 1'b1;
            CPU_RUN <= 1'b1;
        end else begin
            pstate_q <= pstate_d;
            OSC_RUN <= pstate_d != ST_STOP;
            CPU_RUN <= pstate_d == ST_RUN;
        end
    end

    // ------------------------------------------------------------
    // External interrupt qualification
    // ------------------------------------------------------------
    // A polarity change can itself look like an edge once it passes
    // the filter; software should mask before changing polarity.
    reg filt_prev_q;
    wire [`CCIR_QW-1:0] thresh = (src_ctrl & f75) ?
        QUAL_SLOW[`CCIR_QW-1:0] : QUAL_FAST[`CCIR_QW-1:0];
    wire ext_evt;

    ccir_pulse_qual #(
        .W(`CCIR_QW)
    ) u_qual (
        .clk(CLK),
        .rst(sys_rst),
        .din(ext_s2_q ^ ctrl_q[`CCIR_C_POL]),
        .thresh(thresh),
        .dout(filt)
    );

    always @(posedge CLK) begin
        if (sys_rst) begin
            filt_prev_q <= 1'b0;
        end else begin
            filt_prev_q <= filt;
        end
    end

    assign ext_evt = ctrl_q[`CCIR_C_FALL] ? (filt_prev_q & ~filt) :
                     (~filt_prev_q & filt);

    // ------------------------------------------------------------
    // 8-bit timer
    // ------------------------------------------------------------
    reg [15:0] div_q;
    reg int_tick;
    wire tmr_tick;
    wire tmr_evt;

    always @(posedge CLK) begin
        if (sys_rst) begin
            div_q <= 16'h0000;
            int_tick <= 1'b0;
        end else if (!OSC_RUN) begin
            int_tick <= 1'b0;
        end else if (div_q == TICK_DIV[15:0] - 16'h0001) begin
            div_q <= 16'h0000;
            int_tick <= 1'b1;
        end else begin
            div_q <= div_q + 16'h0001;
            int_tick <= 1'b0;
        end
    end

    assign tmr_tick = ctrl_q[`CCIR_C_TEXT] ? ext_evt : int_tick;
    assign tmr_evt = tmr_tick & (tcnt_q == tcmp_q);

    always @(posedge CLK) begin
        if (sys_rst) begin
            tcnt_q <= 8'h00;
        end else if (tmr_evt) begin
            tcnt_q <= 8'h00;
        end else if (tmr_tick) begin
            tcnt_q <= tcnt_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and vectors
    // ------------------------------------------------------------
    // The reset-done flag must survive the system reset, so the
    // status register clears on the pin reset only.
    wire [`CCIR_IW-1:0] iset;
    wire [`CCIR_IW-1:0] iclr;
    wire [`CCIR_IW-1:0] pend = istat_q & imask_q;

    assign iset = {hold_chg & (pstate_q != ST_RUN), por_done,
                   tmr_evt, ext_evt};
    assign iclr = (wr & (PADDR == `CCIR_A_ISTAT)) ?
                  PWDATA[`CCIR_IW-1:0] : {`CCIR_IW{1'b0}};

    always @(posedge CLK) begin
        if (SRST) begin
            istat_q <= {`CCIR_IW{1'b0}};
        end else begin
            istat_q <= (istat_q & ~iclr) | iset;
        end
    end

    always @(posedge CLK) begin
        if (sys_rst) begin
            IRQ <= 1'b0;
            CPU_RST <= 1'b1;
            VEC_ADDR <= `CCIR_VEC_RST;
        end else begin
            IRQ <= |pend;
            CPU_RST <= 1'b0;
            if (pend[`CCIR_I_EXT]) begin
                VEC_ADDR <= `CCIR_VEC_EXT;
            end else if (pend[`CCIR_I_TMR]) begin
                VEC_ADDR <= `CCIR_VEC_TMR;
            end
        end
    end
endmodule

/* verif/ccir_checker.sv */
// Assertion checker for the clock, interrupt and reset block
`timescale 1ns/1ps
`include "ccir_defines.vh"
module ccir_checker (
    input wire CLK,
    input wire SRST,
    input wire PSEL,
    input wire PENABLE,
    input wire PSLVERR,
    input wire HOLD_IN,
    input wire CLOCK_STOP_INSTR,
    input wire CPU_RST,
    input wire [12:0] VEC_ADDR,
    input wire IRQ,
    input wire [1:0] CPU_CLK_SEL,
    input wire [1:0] TIMEBASE_SEL,
    input wire CTRL_XTAL_FB_SEL,
    input wire OSC_RUN,
    input wire CPU_RUN,
    input wire DISC_HALT,
    input wire [3:0] TEST_PORT_BITS
);
default clocking @(posedge CLK); endclocking
default disable iff (SRST);
// ----------------------------------------------------------------
// Sequences
// ----------------------------------------------------------------
sequence rst_release;
    $fell(SRST);
endsequence
sequence stop_req;
    CLOCK_STOP_INSTR && CPU_RUN && !CPU_RST;
endsequence
sequence hold_wake;
    $changed(HOLD_IN) && !CPU_RUN && !CPU_RST;
endsequence
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
a_por_stretch: assert property (rst_release |-> CPU_RST [*8])
    else $error("reset not stretched after release");
a_reset_vector: assert property (CPU_RST && $past(CPU_RST) |->
    VEC_ADDR == `CCIR_VEC_RST)
    else $error("vector not zero in reset");
a_reset_disc: assert property (CPU_RST && $past(CPU_RST) |->
    CPU_CLK_SEL == `CCIR_SEL_DISC)
    else $error("clock not on disc oscillator in reset");
a_timebase_same: assert property (TIMEBASE_SEL == CPU_CLK_SEL)
    else $error("timebase and cpu clock differ");
a_fb_follows: assert property ($stable(CPU_CLK_SEL) &&
    CPU_CLK_SEL != `CCIR_SEL_DISC |->
    CTRL_XTAL_FB_SEL == (CPU_CLK_SEL == `CCIR_SEL_SLOW))
    else $error("feedback select does not match frequency");
a_vector_cause: assert property ($changed(VEC_ADDR) &&
    VEC_ADDR != `CCIR_VEC_RST |-> IRQ && (VEC_ADDR == `CCIR_VEC_EXT ||
    VEC_ADDR == `CCIR_VEC_TMR))
    else $error("vector changed without interrupt");
a_stop_halts: assert property (stop_req |-> ##[1:3] !OSC_RUN)
    else $error("clock stop did not halt oscillator");
a_no_run_stopped: assert property (!OSC_RUN |-> !CPU_RUN)
    else $error("cpu runs with oscillator stopped");
a_hold_wakes: assert property (hold_wake |-> ##[2:8] CPU_RUN)
    else $error("hold change did not wake");
a_halt_test: assert property (DISC_HALT == &$past(TEST_PORT_BITS))
    else $error("disc halt does not follow test bits");
a_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("slave error outside access phase");
endmodule
bind ccir_top ccir_checker chk_i (.CLK, .SRST, .PSEL, .PENABLE,
    .PSLVERR, .HOLD_IN, .CLOCK_STOP_INSTR, .CPU_RST, .VEC_ADDR, .IRQ,
    .CPU_CLK_SEL, .TIMEBASE_SEL, .CTRL_XTAL_FB_SEL, .OSC_RUN, .CPU_RUN,
    .DISC_HALT, .TEST_PORT_BITS);

/* verif/ccir_partner.sv */
// Model of the interrupt source, hold switch and controller supply
`timescale 1ns/1ps
module ccir_partner (
    input wire clk,
    output reg ext_irq,
    output reg hold,
    output reg supply_ok
);
initial begin
    ext_irq = 1'h0;
    hold = 1'h0;
    supply_ok = 1'h1;
end
// Pin held for n cycles; short n gives a sub-width glitch
task automatic pulse(input logic lvl, input int n);
    begin
        @(posedge clk);
        ext_irq <= lvl;
        repeat (n) @(posedge clk);
        ext_irq <= !lvl;
    end
endtask
task automatic drive(input logic lvl);
    begin
        @(posedge clk);
        ext_irq <= lvl;
    end
endtask
task automatic toggle_hold;
    begin
        @(posedge clk);
        hold <= !hold;
    end
endtask
// Supply dips to zero and rises again
task automatic supply_cycle;
    begin
        @(posedge clk);
        supply_ok <= 1'h0;
        repeat (20) @(posedge clk);
        supply_ok <= 1'h1;
    end
endtask
endmodule

/* verif/ccir_top_tb.sv */
// Self-checking bench for the clock, interrupt and reset block
`timescale 1ns/1ps
`include "ccir_defines.vh"
module ccir_top_tb;
localparam logic [7:0] a_ct = `CCIR_A_CTRL;
localparam logic [7:0] a_is = `CCIR_A_ISTAT;
localparam logic [7:0] a_im = `CCIR_A_IMASK;
logic clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0;
logic pwrite = 1'h0, stop = 1'h0, perr;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic pready, pslverr, irq_in, hold, sup_ok, cpu_rst, irq, fb;
logic osc_run, cpu_run, halt;
logic [12:0] vec;
logic [1:0] csel, tsel;
logic [3:0] tbits;
int err_total = 0, checked = 0, cyc = 0;
ccir_top #(.POR_CYCLES(16), .TICK_DIV(4)) dut (.CLK(clk), .SRST(srst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_IRQ_IN(irq_in), .HOLD_IN(hold),
    .CTRL_SUPPLY_OK(sup_ok), .CLOCK_STOP_INSTR(stop), .CPU_RST(cpu_rst),
    .VEC_ADDR(vec), .IRQ(irq), .CPU_CLK_SEL(csel), .TIMEBASE_SEL(tsel),
    .CTRL_XTAL_FB_SEL(fb), .OSC_RUN(osc_run), .CPU_RUN(cpu_run),
    .DISC_HALT(halt), .TEST_PORT_BITS(tbits));
ccir_partner pm (.clk(clk), .ext_irq(irq_in), .hold(hold),
    .supply_ok(sup_ok));
initial forever #4 clk = ~clk;
// Runaway guard; the full run needs about 5800 cycles
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
        err_total++;
        finish_test;
    end
end
// ----------------------------------------------------------------
// Bus and check helpers
// ----------------------------------------------------------------
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    end
endtask
task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e);
    begin
        apb(1'h0, a, 32'h0);
        chk(rd & m, e);
    end
endtask
task automatic wait_rst;
    int n;
    begin
        n = 0;
        while (cpu_rst !== 1'h0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        chk(cpu_rst, 1'h0);
    end
endtask
// ----------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------
task automatic t_regs;
    begin
        rdchk(a_ct, 32'h3f, 32'h0);
        rdchk(`CCIR_A_TCMP, 32'hff, 32'hff);
        chk(csel, `CCIR_SEL_DISC);
        apb(1'h0, 8'h1c, 32'h0);
        chk(perr, 1'h1);
        chk(rd, 32'h0);
    end
endtask
task automatic t_clock;
    logic [1:0] s;
    begin
        for (int i = 0; i < 4; i++) begin
            s = i[0] ? (i[1] ? `CCIR_SEL_SLOW : `CCIR_SEL_FAST) : 2'h0;
            wr(a_ct, i);
            repeat (3) @(posedge clk);
            chk(csel, s);
            chk(tsel, s);
            chk(fb, i[1]);
        end
    end
endtask
task automatic t_irq;
    begin
        wr(a_ct, 32'h0);
        wr(a_is, 32'hf);
        wr(a_im, 32'h1);
        pm.pulse(1'h1, 100);
        rdchk(a_is, 32'h1, 32'h0);
        pm.pulse(1'h1, 200);
        rdchk(a_is, 32'h1, 32'h1);
        chk(irq, 1'h1);
        chk(vec, `CCIR_VEC_EXT);
        wr(a_im, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'h0);
        repeat (200) @(posedge clk);
        wr(a_ct, 32'h3);
        wr(a_is, 32'hf);
        pm.pulse(1'h1, 200);
        rdchk(a_is, 32'h1, 32'h0);
        pm.pulse(1'h1, 1700);
        rdchk(a_is, 32'h1, 32'h1);
    end
endtask
// Rising edge on the inverted input equals a falling pin edge
task automatic t_edges;
    logic [31:0] c [2] = '{32'h8, 32'h4};
    begin
        foreach (c[i]) begin
            wr(a_ct, c[i]);
            repeat (200) @(posedge clk);
            wr(a_is, 32'hf);
            pm.pulse(1'h1, 200);
            rdchk(a_is, 32'h1, 32'h0);
            repeat (200) @(posedge clk);
            rdchk(a_is, 32'h1, 32'h1);
        end
        wr(a_ct, 32'h0);
        repeat (200) @(posedge clk);
    end
endtask
// Internal ticks bring the count to zero before the pin takes over
task automatic t_timer;
    begin
        wr(`CCIR_A_TCMP, 32'h0);
        repeat (1100) @(posedge clk);
        wr(a_ct, 32'h10);
        wr(`CCIR_A_TCMP, 32'h1);
        wr(a_is, 32'hf);
        wr(a_im, 32'h2);
        rdchk(`CCIR_A_TCNT, 32'hff, 32'h0);
        pm.pulse(1'h1, 200);
        rdchk(a_is, 32'h2, 32'h0);
        rdchk(`CCIR_A_TCNT, 32'hff, 32'h1);
        repeat (200) @(posedge clk);
        pm.pulse(1'h1, 200);
        rdchk(a_is, 32'h2, 32'h2);
        chk(vec, `CCIR_VEC_TMR);
        rdchk(`CCIR_A_TCNT, 32'hff, 32'h0);
        wr(a_im, 32'h0);
        wr(a_ct, 32'h0);
    end
endtask
task automatic t_pin;
    begin
        pm.drive(1'h1);
        repeat (4) @(posedge clk);
        rdchk(`CCIR_A_STAT, 32'h1, 32'h1);
        pm.drive(1'h0);
        repeat (4) @(posedge clk);
        rdchk(`CCIR_A_STAT, 32'h1, 32'h0);
    end
endtask
task automatic t_power;
    begin
        wr(a_is, 32'hf);
        @(posedge clk);
        stop <= 1'h1;
        @(posedge clk);
        stop <= 1'h0;
        repeat (4) @(posedge clk);
        chk(osc_run, 1'h0);
        pm.toggle_hold;
        repeat (8) @(posedge clk);
        chk(osc_run, 1'h1);
        rdchk(a_is, 32'h8, 32'h8);
        wr(a_ct, 32'h20);
        repeat (3) @(posedge clk);
        chk(cpu_run, 1'h0);
        pm.toggle_hold;
        repeat (8) @(posedge clk);
        chk(cpu_run, 1'h1);
    end
endtask
task automatic t_test;
    begin
        wr(`CCIR_A_TEST, 32'hf);
        repeat (2) @(posedge clk);
        chk(tbits, 4'hf);
        chk(halt, 1'h1);
        wr(`CCIR_A_TEST, 32'h7);
        repeat (2) @(posedge clk);
        chk(halt, 1'h0);
    end
endtask
task automatic t_supply;
    begin
        wr(a_ct, 32'h1);
        wr(a_is, 32'hf);
        pm.supply_cycle;
        repeat (6) @(posedge clk);
        chk(cpu_rst, 1'h1);
        chk(vec, `CCIR_VEC_RST);
        wait_rst;
        rdchk(a_is, 32'h4, 32'h4);
        chk(csel, `CCIR_SEL_DISC);
    end
endtask
task finish_test;
    begin
        $display("Checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
endtask
initial begin
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    wait_rst;
    repeat (4) @(posedge clk);
    wait_rst;
    t_regs;
    t_clock;
    t_irq;
    t_edges;
    t_timer;
    t_pin;
    t_power;
    t_test;
    t_supply;
    finish_test;
end
endmodule
